// [src/sdram_core.sv]
/*
 behavioural logic of a burst sdram behind its pins, oversampled by
 core_clk_i. assumes the link clock and all pins from the controller
 are slow compared to core_clk_i and change only between their edges.
*/
// Operation
// [R1] each full access moves eight io-width beats, two per link clock
// [R2] controller drives strobe centred in each write data eye
// [R3] device drives read data and strobe, data edge aligned
// [R4] command and address sampled on every rising link clock; the model acts on them only in IDLE
// [R5] write data taken on strobe edges after the write preamble
// [R6] read preamble driven, then data on following strobe edges
// [R7] bursts start at chosen column, sequential wrapping order
// [R8] controller activates a row before reading or writing
// [R9] activate bank and address pick the bank and row
// [R10] read/write bank and address pick bank and start column
// [R11] bursts are full eight beats or chopped to four
// [R12] auto precharge closes the row after the burst
// [R13] controller doubles refresh above hot case temperature
// [R14] self refresh and power-down modes are provided
`timescale 1ns/1ps
`include "sdram_core_defs.svh"
module sdram_core (
  input  wire logic                    core_clk_i,
  input  wire logic                    resetn_i,
  input  wire logic                    link_clk_i,
  input  wire logic                    cke_i,
  input  sdram_core_pkg::cmd_bus_t     cmd_i,
  input  wire logic [`IO_W-1:0]        dq_i,
  input  wire logic                    dqs_i,
  output logic      [`IO_W-1:0]        dq_o,
  output logic                         dq_oe_o,
  output logic                         dqs_o,
  output logic                         dqs_n_o,
  output logic                         dqs_oe_o,
  output logic                         self_refresh_o,
  output logic                         power_down_o
);
  typedef enum logic [2:0] {IDLE, RD_WAIT, RD_PRE, RD_DATA, WR_DATA}
    burst_state_t;

  // two-flop synchronisers for pins sampled by core_clk_i
  logic [2:0] ck_s, dqs_s;
  logic [1:0] cke_s;
  sdram_core_pkg::cmd_bus_t cmd_s1, cmd_s2;
  logic [`IO_W-1:0] dq_s1, dq_s2;

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      ck_s   <= 3'h0;
      dqs_s  <= 3'h0;
      cke_s  <= 2'h0;
      cmd_s1 <= '1;
      cmd_s2 <= '1;
      dq_s1  <= '0;
      dq_s2  <= '0;
    end else begin
      ck_s   <= {ck_s[1:0], link_clk_i};
      dqs_s  <= {dqs_s[1:0], dqs_i};
      cke_s  <= {cke_s[0], cke_i};
      cmd_s1 <= cmd_i;
      cmd_s2 <= cmd_s1;
      dq_s1  <= dq_i;
      dq_s2  <= dq_s1;
    end
  end

  // edge detectors read only synchronised stages
  logic ck_rise, ck_fall, ck_edge, dqs_rise;
  assign ck_rise  = ck_s[1] & ~ck_s[2];
  assign ck_fall  = ~ck_s[1] & ck_s[2];
  assign ck_edge  = ck_rise | ck_fall;
  assign dqs_rise = dqs_s[1] & ~dqs_s[2];

  function automatic sdram_core_pkg::cmd_t decode_cmd(
    input sdram_core_pkg::cmd_bus_t c, input logic cke);
    logic [2:0] rcw;
    rcw = {c.ras_n, c.cas_n, c.we_n};
    if (c.cs_n) decode_cmd = sdram_core_pkg::CMD_NOP;
    else case (rcw)
      3'h3:    decode_cmd = sdram_core_pkg::CMD_ACT;
      3'h5:    decode_cmd = sdram_core_pkg::CMD_RD;
      3'h4:    decode_cmd = sdram_core_pkg::CMD_WR;
      3'h2:    decode_cmd = sdram_core_pkg::CMD_PRE;
      3'h1:    decode_cmd = cke ? sdram_core_pkg::CMD_REF
                                : sdram_core_pkg::CMD_SRE;
      default: decode_cmd = sdram_core_pkg::CMD_NOP;
    endcase
  endfunction : decode_cmd

  // sequential wrap inside the 8-word block
  function automatic logic [`COL_W-1:0] beat_col(
    input logic [`COL_W-1:0] start, input logic [3:0] beat);
    beat_col = {start[`COL_W-1:3], 3'(start[2:0] + beat[2:0])};
  endfunction : beat_col

  logic [`IO_W-1:0] mem [0:`MEM_DEPTH-1];

  sdram_core_pkg::cmd_t cmd;
  assign cmd = decode_cmd(cmd_s2, cke_s[1]);

  burst_state_t state, next_state;
  logic [7:0]            open_bank, next_open_bank;
  logic [`ROW_W-1:0]     row [0:7];
  logic [`ROW_W-1:0]     next_row_val;
  logic                  row_we;
  logic [`BANK_W-1:0]    bank, next_bank;
  logic [`COL_W-1:0]     col, next_col;
  logic [3:0]            beat, next_beat, len, next_len;
  logic [2:0]            wait_cnt, next_wait_cnt;
  logic                  ap, next_ap;
  logic [`IO_W-1:0]      next_dq;
  logic                  next_dq_oe, next_dqs, next_dqs_oe;
  logic                  next_sr, next_pd;
  logic                  mem_we;
  logic [10:0]           mem_addr;

  assign mem_addr = {bank, row[bank][1:0], beat_col(col, beat)};

  always_comb begin
    next_state     = state;
    next_open_bank = open_bank;
    next_row_val   = row[cmd_s2.bank];
    row_we         = 1'b0;
    next_bank      = bank;
    next_col       = col;
    next_beat      = beat;
    next_len       = len;
    next_wait_cnt  = wait_cnt;
    next_ap        = ap;
    next_dq        = dq_o;
    next_dq_oe     = dq_oe_o;
    next_dqs       = dqs_o;
    next_dqs_oe    = dqs_oe_o;
    next_sr        = self_refresh_o;
    next_pd        = power_down_o;
    mem_we         = 1'b0;
    if (ck_rise) begin
      // low-power modes leave when cke comes back
      if (cke_s[1]) begin
        next_sr = 1'b0;
        next_pd = 1'b0;
      end else if (!self_refresh_o && state == IDLE &&
                   cmd != sdram_core_pkg::CMD_SRE) begin
        next_pd = 1'b1;  // [R14]
      end
    end
    case (state)
      IDLE: begin
        if (ck_rise && cke_s[1] && !self_refresh_o) begin  // [R4]
          case (cmd)
            sdram_core_pkg::CMD_ACT: begin
              next_open_bank[cmd_s2.bank] = 1'b1;  // [R9]
              next_row_val = cmd_s2.addr[`ROW_W-1:0];
              row_we = 1'b1;
            end
            sdram_core_pkg::CMD_PRE: begin
              if (cmd_s2.addr[`PRECHARGE_BIT]) next_open_bank = 8'h00;
              else next_open_bank[cmd_s2.bank] = 1'b0;
            end
            sdram_core_pkg::CMD_RD,
            sdram_core_pkg::CMD_WR: begin
              // only open banks serve bursts
              if (open_bank[cmd_s2.bank]) begin  // [R8]
                next_bank = cmd_s2.bank;  // [R10]
                next_col  = cmd_s2.addr[`COL_W-1:0];  // [R7]
                next_len  = cmd_s2.addr[`CHOP_BIT] ? `BEATS_FULL
                                                   : `BEATS_CHOP;  // [R11]
                next_ap   = cmd_s2.addr[`PRECHARGE_BIT];
                next_beat = 4'h0;
                next_wait_cnt = 3'h0;
                next_state = (cmd == sdram_core_pkg::CMD_RD) ? RD_WAIT
                                                            : WR_DATA;
              end
            end
            default: ;
          endcase
        end
        if (ck_rise && !cke_s[1] && cmd == sdram_core_pkg::CMD_SRE) begin
          next_sr = 1'b1;  // [R14]
          next_pd = 1'b0;  // the two low-power modes stay apart
        end
      end
      RD_WAIT: begin
        if (ck_rise) begin
          next_wait_cnt = wait_cnt + 3'h1;
          if (wait_cnt == `CL_EDGES - 3'h1) begin
            next_state  = RD_PRE;
            next_dqs_oe = 1'b1;  // [R6]
            next_dqs    = 1'b0;
          end
        end
      end
      RD_PRE: begin
        if (ck_rise) begin
          next_state = RD_DATA;
          next_dqs   = 1'b1;  // [R6]
          next_dq    = mem[mem_addr];  // [R3]
          next_dq_oe = 1'b1;
          next_beat  = beat + 4'h1;
        end
      end
      RD_DATA: begin
        if (ck_edge) begin  // [R1]
          if (beat == len) begin
            next_state  = IDLE;
            next_dq_oe  = 1'b0;
            next_dqs_oe = 1'b0;
            next_dqs    = 1'b0;
            if (ap) next_open_bank[bank] = 1'b0;  // [R12]
          end else begin
            next_dqs  = ~dqs_o;  // [R3]
            next_dq   = mem[mem_addr];
            next_beat = beat + 4'h1;
          end
        end
      end
      WR_DATA: begin
        // capture on each strobe edge after the preamble
        if (dqs_rise || (beat[0] && dqs_s[2] && !dqs_s[1])) begin  // [R5]
          mem_we    = 1'b1;
          next_beat = beat + 4'h1;
          if (beat + 4'h1 == len) begin
            next_state = IDLE;
            if (ap) next_open_bank[bank] = 1'b0;  // [R12]
          end
        end
      end
      default: next_state = IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      state          <= IDLE;
      open_bank      <= 8'h00;
      bank           <= '0;
      col            <= '0;
      beat           <= 4'h0;
      len            <= `BEATS_FULL;
      wait_cnt       <= 3'h0;
      ap             <= 1'b0;
      dq_o           <= '0;
      dq_oe_o        <= 1'b0;
      dqs_o          <= 1'b0;
      dqs_oe_o       <= 1'b0;
      self_refresh_o <= 1'b0;
      power_down_o   <= 1'b0;
    end else begin
      state          <= next_state;
      open_bank      <= next_open_bank;
      bank           <= next_bank;
      col            <= next_col;
      beat           <= next_beat;
      len            <= next_len;
      wait_cnt       <= next_wait_cnt;
      ap             <= next_ap;
      dq_o           <= next_dq;
      dq_oe_o        <= next_dq_oe;
      dqs_o          <= next_dqs;
      dqs_oe_o       <= next_dqs_oe;
      self_refresh_o <= next_sr;
      power_down_o   <= next_pd;
    end
  end

  // storage arrays have no reset; contents are undefined at power-up
  always_ff @(posedge core_clk_i) begin
    if (row_we) row[cmd_s2.bank] <= next_row_val;
    if (mem_we) mem[mem_addr] <= dq_s2;
  end

  assign dqs_n_o = ~dqs_o;

  a_read_preamble: assert property (@(posedge core_clk_i)  // [R6]
    disable iff (!resetn_i)
    (state == RD_PRE) |-> (dqs_oe_o && !dqs_o && !dq_oe_o));

  a_read_burst_len: assert property (@(posedge core_clk_i)  // [R11]
    disable iff (!resetn_i)
    (state == RD_DATA) |-> (beat <= len));

  sequence s_rd_start;
    state == IDLE ##1 state == RD_WAIT;
  endsequence
  a_read_starts: assert property (@(posedge core_clk_i)  // [R8]
    disable iff (!resetn_i)
    s_rd_start |-> open_bank[bank]);

  a_strobe_pair: assert property (@(posedge core_clk_i)  // [R3]
    disable iff (!resetn_i)
    (dq_oe_o && $past(dq_oe_o) && $changed(dq_o)) |-> $changed(dqs_o));

  a_auto_close: assert property (@(posedge core_clk_i)  // [R12]
    disable iff (!resetn_i)
    (state == WR_DATA && next_state == IDLE && ap) |=>
      !open_bank[$past(bank)]);

  a_sr_idle: assert property (@(posedge core_clk_i)  // [R14]
    disable iff (!resetn_i)
    $rose(self_refresh_o) |-> $past(state) == IDLE);

  a_modes_apart: assert property (@(posedge core_clk_i)  // [R14]
    disable iff (!resetn_i)
    !(self_refresh_o && power_down_o));

  a_data_with_strobe: assert property (@(posedge core_clk_i)  // [R1]
    disable iff (!resetn_i)
    dq_oe_o |-> dqs_oe_o);

  a_wr_len: assert property (@(posedge core_clk_i)  // [R5]
    disable iff (!resetn_i)
    (state == WR_DATA) |-> (beat < len));
endmodule : sdram_core

// [src/sdram_core_defs.svh]
/*
 holds the offsets, field positions and timing counts of the sdram
 access model. assumes it is included once per compile unit.
*/
`ifndef SDRAM_CORE_DEFS_SVH
`define SDRAM_CORE_DEFS_SVH

`define IO_W           4
`define BANK_W         3
`define ROW_W          8
`define COL_W          6
`define BEATS_FULL     4'h8
`define BEATS_CHOP     4'h4
`define PREAMBLE_EDGES 2'h1
`define CL_EDGES       3'h2
`define AP_HOLD        3'h3
`define PRECHARGE_BIT  10
`define CHOP_BIT       12
`define MEM_DEPTH      2048

`endif

// [src/sdram_core_pkg.sv]
/*
 types shared by the sdram access model. assumes the defs header.
*/
package sdram_core_pkg;
  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_ACT,
    CMD_RD,
    CMD_WR,
    CMD_PRE,
    CMD_REF,
    CMD_SRE,
    CMD_PDE
  } cmd_t;

  typedef struct packed {
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [2:0]  bank;
    logic [13:0] addr;
  } cmd_bus_t;
endpackage : sdram_core_pkg

// [verification/ddr_ctrl_model.sv]
/*
 controller model: free link clock, command pins, write bursts.
 assumes the device oversamples every pin with its own clock.
*/
`timescale 1ns/1ps
`include "sdram_core_defs.svh"
module ddr_ctrl_model (
  output logic                     link_clk_o,
  output logic                     cke_o,
  output sdram_core_pkg::cmd_bus_t cmd_o,
  output logic [`IO_W-1:0]         dq_o,
  output logic                     dqs_o
);
  // link edges land 2 ns after core edges, like all other stimulus
  initial begin
    cke_o = 1'b1;
    cmd_o = {4'hf, 3'h0, 14'h0000};
    dq_o = 4'h0;
    dqs_o = 1'b0;
    link_clk_o = 1'b0;
    #27;
    forever #200 link_clk_o = ~link_clk_o;
  end

  // deselected pins show the inverse, never a held value
  task automatic issue(input logic [3:0] code, input logic [2:0] bank,
                       input logic [13:0] addr, input logic cke);
    @(negedge link_clk_o);
    cmd_o = {code, bank, addr};
    cke_o = cke;
    @(negedge link_clk_o);
    cmd_o = {4'hf, ~bank, ~addr};
  endtask : issue

  // hot case: two refreshes per interval, so the rate doubles
  task automatic refresh(input logic hot);
    issue(4'h1, 3'h0, 14'h0000, 1'b1);
    if (hot)
      issue(4'h1, 3'h0, 14'h0000, 1'b1);
  endtask : refresh

  task automatic write_burst(input logic [31:0] data, input int len);
    int i;
    dqs_o = 1'b0;
    @(negedge link_clk_o);
    for (i = 0; i < len; i++) begin
      dq_o = data[4*i +: 4];
      #100 dqs_o = ~dqs_o;
      #100;
    end
    dq_o = ~dq_o;
  endtask : write_burst
endmodule : ddr_ctrl_model

// [verification/sdram_core_tb_top.sv]
/*
 bench: writes bursts via the controller model, reads them at the pins.
 assumes a cas latency of two link clocks and a one clock preamble.
*/
`timescale 1ns/1ps
`include "sdram_core_defs.svh"
module sdram_core_tb_top;
  logic                     core_clk_i;
  logic                     resetn_i;
  logic                     lclk;
  logic                     cke;
  sdram_core_pkg::cmd_bus_t cmd;
  logic [`IO_W-1:0]         dq_w;
  logic [`IO_W-1:0]         dq;
  logic                     dqs_w;
  logic                     dq_oe;
  logic                     dqs;
  logic                     dqs_n;
  logic                     dqs_oe;
  logic                     sr;
  logic                     pd;
  int                       fail_count = 0;
  int                       checks_done = 0;
  int                       cycles = 0;
  logic [3:0]               mem [int];
  logic [1:0]               open_row [8];

  ddr_ctrl_model i_ctrl (.link_clk_o(lclk), .cke_o(cke), .cmd_o(cmd),
                         .dq_o(dq_w), .dqs_o(dqs_w));
  sdram_core i_dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .link_clk_i(lclk), .cke_i(cke), .cmd_i(cmd), .dq_i(dq_w),
    .dqs_i(dqs_w), .dq_o(dq), .dq_oe_o(dq_oe), .dqs_o(dqs),
    .dqs_n_o(dqs_n), .dqs_oe_o(dqs_oe), .self_refresh_o(sr),
    .power_down_o(pd));

  initial core_clk_i = 1'b0;
  always #25 core_clk_i = ~core_clk_i;

  // whole run needs about 1800 cycles
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (fail_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  task automatic check(input string what, input logic [3:0] exp,
                       input logic [3:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask : check

  task automatic settle();
    repeat (40) @(posedge core_clk_i);
    #1;
  endtask : settle

  task automatic act(input logic [2:0] bank, input logic [1:0] row);
    open_row[bank] = row;
    i_ctrl.issue(4'h3, bank, {12'h000, row}, 1'b1);
  endtask : act

  task automatic wr(input logic [2:0] bank, input logic [5:0] col,
                    input logic full, input logic ap,
                    input logic [31:0] data);
    int i;
    for (i = 0; i < (full ? 8 : 4); i++)
      mem[{bank, open_row[bank], col[5:3], col[2:0] + 3'(i)}] =
        data[4*i +: 4];
    i_ctrl.issue(4'h4, bank, {1'b0, full, 1'b0, ap, 4'h0, col}, 1'b1);
    i_ctrl.write_burst(data, full ? 8 : 4);
  endtask : wr

  // window of 120 cycles also proves no extra beats follow
  task automatic rd(input logic [2:0] bank, input logic [5:0] col,
                    input logic ap, input logic full, input int n_exp);
    int n;
    int k;
    int pre;
    logic last;
    n = 0;
    pre = 0;
    i_ctrl.issue(4'h5, bank, {1'b0, full, 1'b0, ap, 4'h0, col}, 1'b1);
    last = dqs;
    for (k = 0; k < 120; k++) begin
      @(posedge core_clk_i);
      #1;
      if (dqs_oe === 1'b1 && n == 0 && dqs === 1'b0)
        pre++;
      if (dqs_oe === 1'b1 && dqs !== last) begin
        if (n == 0)
          check("first edge", 4'h1, {3'h0, dqs});
        if (n < n_exp)
          check("beat", mem[{bank, open_row[bank], col[5:3],
                col[2:0] + 3'(n)}], dq);
        check("strobe pair", {3'h0, ~dqs}, {3'h0, dqs_n});
        check("data drive", 4'h1, {3'h0, dq_oe});
        n++;
      end
      last = dqs;
    end
    if (n_exp > 0)
      check("preamble", 4'h1, {3'h0, pre >= 6});
    check("beat count", 4'(n_exp), 4'(n));
  endtask : rd

  task automatic s_bursts();
    act(3'h3, 2'h1);
    wr(3'h3, 6'h00, 1'b1, 1'b0, 32'h8a3c5e71);
    act(3'h6, 2'h2);
    wr(3'h6, 6'h00, 1'b1, 1'b0, 32'h1f2e3d4c);
    rd(3'h3, 6'h05, 1'b0, 1'b1, 8);
  endtask : s_bursts

  task automatic s_chop();
    wr(3'h3, 6'h06, 1'b0, 1'b0, 32'h0000b96d);
    rd(3'h3, 6'h00, 1'b0, 1'b1, 8);
    rd(3'h3, 6'h02, 1'b0, 1'b0, 4);
  endtask : s_chop

  task automatic s_auto_pre();
    rd(3'h3, 6'h03, 1'b1, 1'b1, 8);
    rd(3'h3, 6'h03, 1'b0, 1'b1, 0);
    wr(3'h6, 6'h00, 1'b1, 1'b1, 32'h5b0e7a92);
    rd(3'h6, 6'h00, 1'b0, 1'b1, 0);
    act(3'h6, 2'h2);
    rd(3'h6, 6'h04, 1'b0, 1'b1, 8);
    i_ctrl.issue(4'h2, 3'h6, 14'h0000, 1'b1);
    rd(3'h6, 6'h00, 1'b0, 1'b1, 0);
  endtask : s_auto_pre

  task automatic s_power();
    i_ctrl.refresh(1'b1);
    settle();
    check("refresh stays awake", 4'h0, {3'h0, sr | pd});
    i_ctrl.issue(4'h2, 3'h0, 14'h0400, 1'b1);
    i_ctrl.issue(4'h7, 3'h0, 14'h0000, 1'b0);
    settle();
    check("power down", 4'h1, {3'h0, pd});
    i_ctrl.issue(4'h7, 3'h0, 14'h0000, 1'b1);
    settle();
    check("power down exit", 4'h0, {3'h0, pd});
    i_ctrl.issue(4'h1, 3'h0, 14'h0000, 1'b0);
    settle();
    check("self refresh", 4'h1, {3'h0, sr});
    check("power down in self refresh", 4'h0, {3'h0, pd});
    i_ctrl.issue(4'h7, 3'h0, 14'h0000, 1'b1);
    settle();
    check("self refresh exit", 4'h0, {3'h0, sr});
    act(3'h3, 2'h1);
    rd(3'h3, 6'h00, 1'b0, 1'b1, 8);
  endtask : s_power

  initial begin
    resetn_i = 1'b0;
    repeat (8) @(posedge core_clk_i);
    #2 resetn_i = 1'b1;
    repeat (8) @(posedge core_clk_i);
    s_bursts();
    s_chop();
    s_auto_pre();
    s_power();
    wrap_up();
  end
endmodule : sdram_core_tb_top
